// ==== prs_regs.svh ====
// Command codes, field positions, defaults and timing counts of the converter link
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_CMD_RESET     8'h06
`define PRS_CMD_WR_ALL    8'h43
`define PRS_CMD_WR_CFG1   8'h44
`define PRS_CMD_WR_HI     4'h4
`define PRS_RESET_LOW     3'h7
`define PRS_TEMPERATURE_SELECT_BIT  1
`define PRS_TEMPERATURE_SELECT_MASK 8'h02
`define PRS_DR_LSB        5
`define PRS_TEMPERATURE_SELECT_REG  2'h1
`define PRS_CFG0_DEF      8'h00
`define PRS_CFG1_DEF      8'h04
`define PRS_CFG2_DEF      8'h00
`define PRS_CFG3_DEF      8'h00
`define PRS_TEMP_W        14
`define PRS_PAD_W         10
`define PRS_RES_BITS      5'h18
`define PRS_P_HI_LIM      32'sh007f_ffff
`define PRS_P_LO_LIM      32'shff80_0000
`define PRS_P_MAX         24'h7f_ffff
`define PRS_P_MIN         24'h80_0000
`define PRS_CLK_NS        50
`define PRS_SCLK_HALF_NS  200
`define PRS_HALF_CYC      ((`PRS_SCLK_HALF_NS) / (`PRS_CLK_NS))
`define PRS_GAP_NS        1000
`define PRS_GAP_CYC       (((`PRS_GAP_NS) + (`PRS_CLK_NS) - 1) / (`PRS_CLK_NS))
`define PRS_BITS_CMD      6'h08
`define PRS_BITS_LONG     6'h28
`define PRS_FIFO_DEPTH    8
`define PRS_WORD_W        25
`endif

// ==== prs_pkg.sv ====
// Types for the host and converter ends of the link; only prs_cfg_t is used by both
package prs_pkg;
    typedef logic [3:0][7:0] prs_cfg_t;

    typedef enum logic [2:0] {
        S_BOOT  = 3'b000,
        S_SHIFT = 3'b001,
        S_GAP   = 3'b010,
        S_IDLE  = 3'b011,
        S_PUSH  = 3'b100
    } prs_hstate_t;

    typedef enum logic [1:0] {
        F_RST  = 2'b00,
        F_INIT = 2'b01,
        F_TEMP = 2'b10,
        F_PRES = 2'b11
    } prs_frame_t;

    typedef struct packed {
        prs_hstate_t state;
        prs_frame_t  frame;
        logic [3:0]  div;
        logic [5:0]  gap;
        logic [5:0]  bits;
        logic        sclk;
        logic        mosi;
        logic        cs_n;
        logic [39:0] tx_sh;
        logic [23:0] rx_sh;
        logic        miso_s1;
        logic        miso_s2;
        logic        pend;
        logic [24:0] word;
    } prs_host_st_t;

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_d;
        logic        sel_s1;
        logic        sel_s2;
        logic        din_s1;
        logic        din_s2;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_cnt;
        logic [2:0]  wr_left;
        logic [1:0]  wr_idx;
        logic        hit1;
        prs_cfg_t    cfg;
        logic [23:0] tx_sh;
        logic [4:0]  tx_cnt;
        logic        dout;
        logic        oe_n;
    } prs_adc_st_t;
endpackage

// ==== prs_if.sv ====
// Converter link wires shared by host and converter
`timescale 1ns/1ns
interface prs_if;
    logic adc_select_n;     // Converter select, low active
    logic memory_select_n;  // Memory select, low active
    logic sclk;             // Serial clock from host
    logic mosi;             // Host to converter data
    logic miso_o;           // Converter output value
    logic miso_oe_n;        // Converter drives miso while low
    logic miso;             // Resolved line, pulled up when undriven

    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport host (output adc_select_n, output memory_select_n, output sclk, output mosi, input miso);
    modport adc (input adc_select_n, input memory_select_n, input sclk, input mosi,
                 output miso_o, output miso_oe_n);
endinterface

// ==== prs_fifo.sv ====
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ns
module prs_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,        // System clock
    input  wire logic             reset_n,    // Async reset, low active
    input  wire logic             in_valid,   // Write request
    output logic                  in_ready,   // Room for a word
    input  wire logic [WIDTH-1:0] in_data,    // Write word
    output logic                  out_valid,  // Word available
    input  wire logic             out_ready,  // Reader takes word
    output logic [WIDTH-1:0]      out_data    // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } prs_fifo_st_t;

    prs_fifo_st_t r;
    prs_fifo_st_t n;
    logic         do_wr;
    logic         do_rd;

    assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rp];

    always_comb begin
        n     = r;
        do_wr = in_valid & in_ready;
        do_rd = out_valid & out_ready;
        if (do_wr) begin
            n.mem[r.wp] = in_data;
            n.wp        = AW'(r.wp + 1'b1);
        end
        if (do_rd) begin
            n.rp = AW'(r.rp + 1'b1);
        end
        n.cnt = (AW+1)'(r.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // prs_fifo

// ==== prs_adc.sv ====
// Converter end: command decode, configuration registers and result shifter
`timescale 1ns/1ns
`include "prs_regs.svh"
module prs_adc (
    prs_if.adc                  link,           // Serial link, converter side
    input  wire logic           clk,            // System clock
    input  wire logic           reset_n,        // Async reset, low active
    input  wire logic [13:0]    temp_code,      // Temperature, two's complement
    input  wire logic [31:0]    pressure_level, // Signed pressure input
    output prs_pkg::prs_cfg_t   cfg_regs,       // Configuration registers
    output logic                temp_mode       // Temperature selected
);
    import prs_pkg::*;

    prs_adc_st_t r;
    prs_adc_st_t n;
    logic        rise;
    logic        fall;
    logic [7:0]  byte_v;
    logic [23:0] p_clip;
    prs_cfg_t    cfg_def;

    assign cfg_def = {`PRS_CFG3_DEF, `PRS_CFG2_DEF, `PRS_CFG1_DEF, `PRS_CFG0_DEF};

    // Saturate out-of-range input to the end codes
    always_comb begin
        if ($signed(pressure_level) > `PRS_P_HI_LIM) begin
            p_clip = `PRS_P_MAX;
        end else if ($signed(pressure_level) < `PRS_P_LO_LIM) begin
            p_clip = `PRS_P_MIN;
        end else begin
            p_clip = pressure_level[23:0];
        end
    end

    always_comb begin
        n         = r;
        n.sclk_s1 = link.sclk;
        n.sclk_s2 = r.sclk_s1;
        n.sclk_d  = r.sclk_s2;
        n.sel_s1  = link.adc_select_n;
        n.sel_s2  = r.sel_s1;
        n.din_s1  = link.mosi;
        n.din_s2  = r.din_s1;
        rise      = r.sclk_s2 & ~r.sclk_d;
        fall      = ~r.sclk_s2 & r.sclk_d;
        byte_v    = {r.rx_sh[6:0], r.din_s2};
        if (r.sel_s2) begin
            // Deselected frame ends every transfer in progress
            n.oe_n    = 1'b1;
            n.dout    = 1'b0;
            n.rx_cnt  = '0;
            n.wr_left = '0;
            n.tx_cnt  = '0;
        end else begin
            n.oe_n = 1'b0;
            if (rise) begin
                if (r.tx_cnt != '0) begin
                    n.dout   = r.tx_sh[23];
                    n.tx_sh  = {r.tx_sh[22:0], 1'b0};
                    n.tx_cnt = r.tx_cnt - 5'h01;
                end else begin
                    n.dout = 1'b0;
                end
            end
            if (fall) begin
                n.rx_sh  = byte_v;
                n.rx_cnt = r.rx_cnt + 3'h1;
                if (r.rx_cnt == `PRS_RESET_LOW) begin
                    if (r.wr_left != '0) begin
                        n.cfg[r.wr_idx] = byte_v;
                        n.wr_idx        = r.wr_idx + 2'h1;
                        n.wr_left       = r.wr_left - 3'h1;
                        if (r.wr_idx == `PRS_TEMPERATURE_SELECT_REG) begin
                            n.hit1 = 1'b1;
                        end
                        // Result follows a completed write that touched register 1
                        if ((r.wr_left == 3'h1) && n.hit1) begin
                            n.tx_cnt = `PRS_RES_BITS;
                            n.tx_sh  = n.cfg[`PRS_TEMPERATURE_SELECT_REG][`PRS_TEMPERATURE_SELECT_BIT] ?
                                       {temp_code, {`PRS_PAD_W{1'b0}}} : p_clip;
                        end
                    end else if (byte_v == `PRS_CMD_RESET) begin
                        n.cfg = cfg_def;
                    end else if (byte_v[7:4] == `PRS_CMD_WR_HI) begin
                        n.wr_idx  = byte_v[3:2];
                        n.wr_left = {1'b0, byte_v[1:0]} + 3'h1;
                        n.hit1    = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r        <= '0;
            r.sel_s1 <= 1'b1;
            r.sel_s2 <= 1'b1;
            r.oe_n   <= 1'b1;
            r.cfg    <= {`PRS_CFG3_DEF, `PRS_CFG2_DEF, `PRS_CFG1_DEF, `PRS_CFG0_DEF};
        end else begin
            r <= n;
        end
    end

    assign link.miso_o    = r.dout;
    assign link.miso_oe_n = r.oe_n;
    assign cfg_regs       = r.cfg;
    assign temp_mode      = r.cfg[`PRS_TEMPERATURE_SELECT_REG][`PRS_TEMPERATURE_SELECT_BIT];
endmodule // prs_adc

// ==== prs_host.sv ====
// Host end: power-up sequence, mode requests and result collection
// How it works
// - Reset command restores configuration defaults
// - Memory select high before converter select low
// - Reset command sent first after power-up
// - Write all four registers in one command
// - Init frame is command plus four bytes
// - Collect temperature and pressure as a pair
// - Temperature request sets select bit in register 1
// - Pressure request clears select bit in register 1
// - Result starts at next rising clock edge
// - Temperature frame 24 bits, keep first 14
// - Temperature field is two's complement
// - Negative codes negated, sign kept separately
// - Pressure is 24-bit two's complement, MSB first
// - Pressure code clips at both full scales
// - Never both selects low together
// - Clock idles low, data sampled on falling edge; the host samples converter data at the end of the low half, as the clock rises
// - Write command: fixed nibble, register, count-1
`timescale 1ns/1ns
`include "prs_regs.svh"
module prs_host (
    prs_if.host                 link,        // Serial link, host side
    input  wire logic           clk,         // System clock
    input  wire logic           reset_n,     // Async reset, low active
    input  prs_pkg::prs_cfg_t   cfg_default, // Defaults copied from memory
    input  wire logic [2:0]     rate_sel,    // Data rate field
    input  wire logic           start,       // Request one reading pair
    output logic                idle,        // Ready for a request
    output logic                out_valid,   // Result word available
    input  wire logic           out_ready,   // Result word taken
    output logic [24:0]         out_word     // Tag and result
);
    import prs_pkg::*;

    prs_host_st_t r;
    prs_host_st_t n;
    logic         go;
    prs_frame_t   go_f;
    logic         push_v;
    logic         push_rdy;
    logic [13:0]  t_code;
    logic [13:0]  t_mag;

    function automatic logic [39:0] frame_bits(prs_frame_t f, prs_cfg_t c, logic [2:0] rate);
        logic [7:0] c1;
        c1         = {rate, c[1][`PRS_DR_LSB-1:0]};
        frame_bits = '0;
        unique case (f)
            F_RST: begin
                frame_bits = {`PRS_CMD_RESET, 32'h0000_0000};
            end
            F_INIT: begin
                frame_bits = {`PRS_CMD_WR_ALL, c[0], c[1], c[2], c[3]};
            end
            F_TEMP: begin
                frame_bits = {`PRS_CMD_WR_CFG1, c1 | `PRS_TEMPERATURE_SELECT_MASK, 24'h00_0000};
            end
            F_PRES: begin
                frame_bits = {`PRS_CMD_WR_CFG1, c1 & ~`PRS_TEMPERATURE_SELECT_MASK, 24'h00_0000};
            end
        endcase
    endfunction

    // Only the leading 14 bits carry temperature
    assign t_code = r.rx_sh[23:`PRS_PAD_W];
    assign t_mag  = t_code[`PRS_TEMP_W-1] ? 14'(~t_code + 14'h0001) : t_code;

    always_comb begin
        n         = r;
        go        = 1'b0;
        go_f      = F_RST;
        push_v    = 1'b0;
        n.miso_s1 = link.miso;
        n.miso_s2 = r.miso_s1;
        if (start) begin
            n.pend = 1'b1;
        end
        unique case (r.state)
            S_BOOT: begin
                // Memory select already high from reset; open converter frame later
                n.gap = r.gap + 6'h01;
                if (r.gap == 6'(`PRS_GAP_CYC - 1)) begin
                    go   = 1'b1;
                    go_f = F_RST;
                end
            end
            S_SHIFT: begin
                if (r.div == 4'(`PRS_HALF_CYC - 1)) begin
                    n.div = '0;
                    if (r.sclk) begin
                        n.sclk = 1'b0;
                    end else begin
                        // Sample late in the low half to cover the converter's sync delay
                        n.rx_sh = {r.rx_sh[22:0], r.miso_s2};
                        if (r.bits == '0) begin
                            n.cs_n  = 1'b1;
                            n.mosi  = 1'b0;
                            n.gap   = '0;
                            n.state = S_GAP;
                        end else begin
                            n.sclk  = 1'b1;
                            n.mosi  = r.tx_sh[39];
                            n.tx_sh = {r.tx_sh[38:0], 1'b0};
                            n.bits  = r.bits - 6'h01;
                        end
                    end
                end else begin
                    n.div = r.div + 4'h1;
                end
            end
            S_GAP: begin
                n.gap = r.gap + 6'h01;
                if (r.gap == 6'(`PRS_GAP_CYC - 1)) begin
                    unique case (r.frame)
                        F_RST: begin
                            go   = 1'b1;
                            go_f = F_INIT;
                        end
                        F_INIT: begin
                            n.state = S_IDLE;
                        end
                        F_TEMP: begin
                            n.word  = {1'b1, t_code[`PRS_TEMP_W-1], 9'h000, t_mag};
                            n.state = S_PUSH;
                        end
                        F_PRES: begin
                            n.word  = {1'b0, r.rx_sh};
                            n.state = S_PUSH;
                        end
                    endcase
                end
            end
            S_IDLE: begin
                if (r.pend) begin
                    n.pend = start;
                    go     = 1'b1;
                    go_f   = F_TEMP;
                end
            end
            S_PUSH: begin
                // A full FIFO holds the sequence here
                push_v = 1'b1;
                if (push_rdy) begin
                    if (r.frame == F_TEMP) begin
                        go   = 1'b1;
                        go_f = F_PRES;
                    end else begin
                        n.state = S_IDLE;
                    end
                end
            end
            default: begin
                n.state = S_BOOT;
                n.gap   = '0;
            end
        endcase
        if (go) begin
            n.state = S_SHIFT;
            n.frame = go_f;
            n.tx_sh = frame_bits(go_f, cfg_default, rate_sel);
            n.bits  = (go_f == F_RST) ? `PRS_BITS_CMD : `PRS_BITS_LONG;
            n.cs_n  = 1'b0;
            n.sclk  = 1'b0;
            n.div   = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r         <= '0;
            r.cs_n    <= 1'b1;
            r.miso_s1 <= 1'b1;
            r.miso_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    prs_fifo #(
        .WIDTH (`PRS_WORD_W),
        .DEPTH (`PRS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (push_v),
        .in_ready  (push_rdy),
        .in_data   (r.word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );

    // Memory is never addressed here, so its select stays high
    assign link.memory_select_n = 1'b1;
    assign link.adc_select_n    = r.cs_n;
    assign link.sclk            = r.sclk;
    assign link.mosi            = r.mosi;
    assign idle                 = (r.state == S_IDLE) && !r.pend;
endmodule // prs_host

// ==== prs_link_chk.sv ====
// Timing and framing assertions on the converter link
`timescale 1ns/1ns
module prs_link_chk (
    input wire logic clk,             // System clock
    input wire logic reset_n,         // Host reset, low active
    input wire logic adc_select_n,    // Converter select
    input wire logic memory_select_n, // Memory select
    input wire logic sclk,            // Serial clock
    input wire logic mosi,            // Host data
    input wire logic miso_o,          // Converter data
    input wire logic miso_oe_n        // Converter drive enable
);
    int unsigned rise_cnt_r;
    int unsigned high_cnt_r;
    logic        sclk_d_r;

    // Saturates so a long idle cannot wrap the gap count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_r <= 0;
            high_cnt_r <= 0;
            sclk_d_r   <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
            if (adc_select_n)
                rise_cnt_r <= 0;
            else if (sclk && !sclk_d_r)
                rise_cnt_r <= rise_cnt_r + 1;
            if (!adc_select_n)
                high_cnt_r <= 0;
            else if (high_cnt_r < 1000)
                high_cnt_r <= high_cnt_r + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence high_half;
        sclk[*4] ##1 !sclk;
    endsequence
    sequence deselected;
        adc_select_n[*6];
    endsequence
    // Sync delay of the converter leaves two clocks before the bit is settled
    sequence fall_driven;
        $fell(sclk) && !adc_select_n ##2 !miso_oe_n;
    endsequence

    a_selects_exclusive: assert property (!(!adc_select_n && !memory_select_n))
        else $error("both selects low");
    a_memory_idle: assert property (memory_select_n)
        else $error("memory select not held high");
    a_sclk_parked: assert property (adc_select_n |-> !sclk)
        else $error("serial clock high outside frame");
    a_sclk_high_half: assert property ($rose(sclk) |-> high_half)
        else $error("serial clock high half not four cycles");
    a_sclk_low_half: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("serial clock low half too short");
    a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while clock high");
    a_miso_held: assert property (fall_driven |-> $stable(miso_o) ##1 $stable(miso_o))
        else $error("converter data moved in low half");
    a_output_release: assert property (deselected |-> miso_oe_n)
        else $error("converter drives while deselected");
    a_frame_bits: assert property ($rose(adc_select_n) |-> rise_cnt_r == 8 || rise_cnt_r == 40)
        else $error("frame length not 8 or 40 bits");
    a_frame_gap: assert property ($fell(adc_select_n) |-> high_cnt_r >= 20)
        else $error("select gap too short");
endmodule // prs_link_chk

// ==== pressure_adc_spi_readout_bench.sv ====
// Testbench joining host and converter ends over the link
`timescale 1ns/1ns
module pressure_adc_spi_readout_bench;
    import prs_pkg::*;
    logic        clk, rst_host_n, rst_adc_n, start, out_ready, out_valid, idle, temp_mode;
    logic [2:0]  rate_sel;
    logic [13:0] temp_code;
    logic [31:0] pressure_level;
    logic [24:0] out_word;
    prs_cfg_t    cfg_default, cfg_regs;
    int          fail_count, samples_checked;

    prs_if link ();
    prs_host u_prs_host (.link(link.host), .clk(clk), .reset_n(rst_host_n), .cfg_default(cfg_default),
        .rate_sel(rate_sel), .start(start), .idle(idle), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word));
    prs_adc u_prs_adc (.link(link.adc), .clk(clk), .reset_n(rst_adc_n), .temp_code(temp_code),
        .pressure_level(pressure_level), .cfg_regs(cfg_regs), .temp_mode(temp_mode));
    prs_link_chk u_prs_link_chk (.clk(clk), .reset_n(rst_host_n), .adc_select_n(link.adc_select_n),
        .memory_select_n(link.memory_select_n), .sclk(link.sclk), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe_n(link.miso_oe_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [31:0] temp_exp(input logic [13:0] t);
        logic [13:0] m;
        m = t[13] ? (~t + 14'h0001) : t;
        return {7'h00, 1'b1, t[13], 9'h000, m};
    endfunction

    function automatic logic [31:0] pres_exp(input logic [31:0] p);
        if ($signed(p) > 32'sh007f_ffff)
            return 32'h007f_ffff;
        if ($signed(p) < 32'shff80_0000)
            return 32'h0080_0000;
        return {8'h00, p[23:0]};
    endfunction

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (idle !== 1'b1 && n < 2000);
        chk("idle wait", 32'(n < 2000), 32'h0000_0001);
    endtask

    task automatic wait_sel(input logic v);
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (link.adc_select_n !== v && n < 1000);
        chk("select wait", 32'(n < 1000), 32'h0000_0001);
    endtask

    // Word is captured before ready so the handshake edge takes it
    task automatic get_word(output logic [24:0] w);
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (out_valid !== 1'b1 && n < 3000);
        chk("word wait", 32'(n < 3000), 32'h0000_0001);
        w = out_word;
        out_ready = 1'b1;
        step(1);
        out_ready = 1'b0;
    endtask

    task automatic pulse_start();
        start = 1'b1;
        step(1);
        start = 1'b0;
    endtask

    task automatic power_up();
        wait_idle();
        chk("cfg after init", cfg_regs, 32'h0040_840a);
        chk("mode after init", 32'(temp_mode), 32'h0000_0000);
    endtask

    task automatic read_pair(input logic [2:0] rate, input logic [13:0] t, input logic [31:0] p);
        logic [24:0] w;
        rate_sel = rate;
        temp_code = t;
        pressure_level = p;
        pulse_start();
        get_word(w);
        chk("temp mode", 32'(temp_mode), 32'h0000_0001);
        chk("reg1 temp", 32'(cfg_regs[1]), {24'h00_0000, rate, 5'h06});
        chk("temp word", 32'(w), temp_exp(t));
        get_word(w);
        chk("pressure word", 32'(w), pres_exp(p));
        chk("reg1 pressure", 32'(cfg_regs[1]), {24'h00_0000, rate, 5'h04});
        chk("pressure mode", 32'(temp_mode), 32'h0000_0000);
        wait_idle();
    endtask

    task automatic pairs();
        logic [13:0] tt [8] = '{14'h0960, 14'h3ce0, 14'h1fff, 14'h2000, 14'h0000, 14'h3ff8, 14'h0c80, 14'h3920};
        logic [31:0] pp [8] = '{32'h0000_0000, 32'h0000_0001, 32'hffff_ffff, 32'h007f_ffff,
                                32'h0100_0000, 32'h8000_0000, 32'hff80_0000, 32'hff7f_ffff};
        for (int i = 0; i < 8; i++)
            read_pair(3'(i), tt[i], pp[i]);
    endtask

    // Fills the result buffer, then checks the host holds the link while full
    task automatic fill_fifo();
        logic [24:0] w;
        rate_sel = 3'h2;
        temp_code = 14'h3ce0;
        pressure_level = 32'h0000_1234;
        for (int i = 0; i < 4; i++) begin
            pulse_start();
            wait_idle();
        end
        pulse_start();
        for (int i = 0; i < 3; i++) begin
            step(3);
            pulse_start();
        end
        step(900);
        chk("select while full", 32'(link.adc_select_n), 32'h0000_0001);
        chk("busy while full", 32'(idle), 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            get_word(w);
            chk("drained word", 32'(w), i[0] ? pres_exp(32'h0000_1234) : temp_exp(14'h3ce0));
        end
        wait_idle();
        step(50);
        chk("buffer empty", 32'(out_valid), 32'h0000_0000);
    endtask

    task automatic host_restart();
        rst_host_n = 1'b0;
        step(2);
        rst_host_n = 1'b1;
        wait_sel(1'b0);
        wait_sel(1'b1);
        step(10);
        chk("cfg after reset cmd", cfg_regs, 32'h0000_0400);
        power_up();
    endtask

    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_host_n = 1'b0;
        rst_adc_n = 1'b0;
        start = 1'b0;
        out_ready = 1'b0;
        rate_sel = 3'h0;
        temp_code = 14'h0000;
        pressure_level = 32'h0000_0000;
        cfg_default = 32'h0040_840a;
        step(5);
        chk("reset cfg", cfg_regs, 32'h0000_0400);
        rst_host_n = 1'b1;
        rst_adc_n = 1'b1;
        power_up();
        pairs();
        fill_fifo();
        host_restart();
        results();
    end

    // Expected run is near 12000 clocks; this allows more than three times that
    initial begin
        #2_000_000;
        fail_count++;
        results();
    end
endmodule // pressure_adc_spi_readout_bench
